// *** bfu_defines.svh ***
`ifndef BFU_DEFINES_SVH
`define BFU_DEFINES_SVH

// register offsets on the plain register port (byte addresses)
`define BFU_OFF_FLAGS  8'h00
`define BFU_OFF_STATUS 8'h04
`define BFU_OFF_RETIRE 8'h08

// bit positions inside the status flags register
`define BFU_FLAG_C 0
`define BFU_FLAG_Z 1
`define BFU_FLAG_N 2
`define BFU_FLAG_V 3
`define BFU_FLAG_S 4
`define BFU_FLAG_H 5
`define BFU_FLAG_T 6
`define BFU_FLAG_I 7

// field positions inside the unit status register
`define BFU_STAT_BUSY   0
`define BFU_STAT_OP_LSB 4
`define BFU_STAT_OP_MSB 7

// reset values
`define BFU_FLAGS_RST  8'h00
`define BFU_RETIRE_RST 16'h0000

`endif

// *** bfu_flags.sv ***
`timescale 1ns/10ps
`include "bfu_defines.svh"
// next value of the status flags register for one issued instruction
module bfu_flags
  import bfu_pkg::*;
(
  input  wire bfu_op_t    op_i,     // instruction being issued
  input  wire logic [7:0] flags_i,  // current flags
  input  wire logic [2:0] sel_i,    // flag index for set/clear
  input  wire logic       tbit_i,   // selected register bit for bit store
  input  wire logic [3:0] arith_i,  // {v, n, z, c} from the shifter
  output wire logic [7:0] flags_o   // flags after the instruction
);

  // only the five shift/rotate forms touch arithmetic flags; swap does not
  wire shift_op = (op_i == bfu_logic_left_shift_op)   | (op_i == bfu_logic_right_shift_op) |
                  (op_i == bfu_rotate_left_carry_op)  | (op_i == bfu_rotate_right_carry_op) |
                  (op_i == bfu_arith_right_shift_op);

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_flag
      // this bit is the one named by a set/clear instruction
      wire hit     = (sel_i == 3'(gi));
      wire do_set  = (op_i == bfu_generic_flag_set_op) & hit;
      wire do_clr  = (op_i == bfu_generic_flag_clear_op) & hit;
      wire do_tst  = (op_i == bfu_bit_to_transfer_flag_op) & (gi == `BFU_FLAG_T);
      wire do_ari  = shift_op & (gi <= `BFU_FLAG_V);
      // every other instruction leaves the bit as it was
      assign flags_o[gi] = do_set ? 1'b1 :
                           do_clr ? 1'b0 :
                           do_tst ? tbit_i :
                           do_ari ? arith_i[gi] : flags_i[gi];
    end
  endgenerate

endmodule : bfu_flags

// *** bfu_pkg.sv ***
package bfu_pkg;

  // instruction codes presented on the issue port
  typedef enum logic [3:0] {
    bfu_idle_instruction         = 4'h0,
    bfu_io_bit_set_op            = 4'h1,
    bfu_io_bit_clear_op          = 4'h2,
    bfu_logic_left_shift_op      = 4'h3,
    bfu_logic_right_shift_op     = 4'h4,
    bfu_rotate_left_carry_op     = 4'h5,
    bfu_rotate_right_carry_op    = 4'h6,
    bfu_arith_right_shift_op     = 4'h7,
    bfu_nibble_swap_op           = 4'h8,
    bfu_generic_flag_set_op      = 4'h9,
    bfu_generic_flag_clear_op    = 4'hA,
    bfu_bit_to_transfer_flag_op  = 4'hB,
    bfu_transfer_flag_to_bit_op  = 4'hC,
    bfu_sleep_op                 = 4'hD,
    bfu_watchdog_restart_op      = 4'hE
  } bfu_op_t;

  // issue sequencer states, one-hot
  typedef enum logic [1:0] {
    bfu_st_idle     = 2'b01,
    bfu_st_io_write = 2'b10
  } bfu_state_t;

endpackage : bfu_pkg

// *** bfu_shift.sv ***
`timescale 1ns/10ps
// shift, rotate and swap datapath with its arithmetic flag results
module bfu_shift
  import bfu_pkg::*;
(
  input  wire bfu_op_t    op_i,      // instruction being issued
  input  wire logic [7:0] data_i,    // working register operand
  input  wire logic       carry_i,   // carry flag before the instruction
  output wire logic [7:0] result_o,  // shifted value
  output wire logic       carry_o,   // carry out
  output wire logic       zero_o,    // result is zero
  output wire logic       neg_o,     // result bit 7
  output wire logic       ovf_o      // negative xor carry
);

  // per-operation results, all computed in parallel
  wire [7:0] lsl_val = {data_i[6:0], 1'b0};
  wire [7:0] lsr_val = {1'b0, data_i[7:1]};
  wire [7:0] rol_val = {data_i[6:0], carry_i};
  wire [7:0] ror_val = {carry_i, data_i[7:1]};
  wire [7:0] asr_val = {data_i[7], data_i[7:1]};
  wire [7:0] swp_val = {data_i[3:0], data_i[7:4]};

  // left moves shift bit 7 out, right moves shift bit 0 out
  wire left_op = (op_i == bfu_logic_left_shift_op) | (op_i == bfu_rotate_left_carry_op);

  assign result_o = (op_i == bfu_logic_left_shift_op)   ? lsl_val :
                    (op_i == bfu_logic_right_shift_op)  ? lsr_val :
                    (op_i == bfu_rotate_left_carry_op)  ? rol_val :
                    (op_i == bfu_rotate_right_carry_op) ? ror_val :
                    (op_i == bfu_arith_right_shift_op)  ? asr_val : swp_val;

  // flag results; only consumed for the five shift/rotate forms
  assign carry_o = left_op ? data_i[7] : data_i[0];
  assign zero_o  = (result_o == 8'h00);
  assign neg_o   = result_o[7];
  assign ovf_o   = result_o[7] ^ carry_o;

endmodule : bfu_shift

// *** bfu_unit.sv ***
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/10ps
`include "bfu_defines.svh"
// Contract
// - I/O bit set: bit to one, two cycles
// - I/O bit clear: bit to zero, two cycles
// - rotate left through carry, flags, one cycle
// - rotate right through carry, flags, one cycle
// - arithmetic right shift keeps bit seven
// - bit store copies register bit into T
// - bit load copies T into register bit
// - interrupt enable sets I only, one cycle
// - interrupt disable clears I only, one cycle
// - signed-test flag set and clear alone
// - overflow flag set and clear alone
// - half-carry flag set and clear alone
// - sleep issues in one cycle, hands off
// - watchdog restart pulses in one cycle
module bfu_unit
  import bfu_pkg::*;
(
  input  wire logic        mclk_i,         // core clock
  input  wire logic        rst_i,          // synchronous reset, active high
  // instruction issue port
  input  wire logic        op_valid_i,     // instruction offered
  input  wire bfu_op_t     op_code_i,      // which instruction
  input  wire logic [2:0]  op_bit_i,       // bit or flag index
  input  wire logic [4:0]  op_rd_addr_i,   // working register number
  input  wire logic [7:0]  op_rd_data_i,   // working register value
  input  wire logic [5:0]  op_io_addr_i,   // I/O register address
  input  wire logic [7:0]  op_io_data_i,   // current I/O register value
  output logic             op_ready_o,     // instruction can be taken
  // working register write-back
  output logic             rd_we_o,        // write-back strobe
  output logic [4:0]       rd_addr_o,      // write-back register number
  output logic [7:0]       rd_data_o,      // write-back value
  // I/O register write
  output logic             io_we_o,        // I/O write strobe
  output logic [5:0]       io_addr_o,      // I/O write address
  output logic [7:0]       io_data_o,      // I/O write value
  // hand-offs to sleep and watchdog logic
  output logic             sleep_req_o,    // one-cycle sleep request
  output logic             wdt_restart_o,  // one-cycle watchdog restart
  output logic [7:0]       flags_o,        // status flags register
  // software register port
  input  wire logic [7:0]  reg_addr_i,     // byte address
  input  wire logic [31:0] reg_wdata_i,    // write data
  input  wire logic        reg_we_i,       // write strobe
  input  wire logic        reg_re_i,       // read strobe
  output logic [31:0]      reg_rdata_o     // read data, one cycle later
);

  // shared decoding
  // helpers and class wires that the paths below read, some by one path only;
  // all of them look at the issue port in the offer cycle

  // one-hot mask for a bit index; used by the I/O ops and by bit load
  function automatic logic [7:0] bfu_bit_mask(input logic [2:0] idx);
    bfu_bit_mask = 8'h01 << idx;
  endfunction : bfu_bit_mask

  bfu_state_t  state;        // issue sequencer
  bfu_state_t  next_state;   // sequencer next value
  logic [15:0] retire_cnt;   // instructions taken since reset or clear
  logic [3:0]  last_op;      // code of the last instruction taken

  // an instruction is taken only when both sides agree
  // ready is registered, so an op never sees its own stall cycle
  wire accept = op_valid_i & op_ready_o;

  // instruction class decode, one wire per group
  wire is_io_set = (op_code_i == bfu_io_bit_set_op);
  wire is_io_clr = (op_code_i == bfu_io_bit_clear_op);
  wire is_io_op  = is_io_set | is_io_clr;
  wire is_shift  = (op_code_i == bfu_logic_left_shift_op)   |
                   (op_code_i == bfu_logic_right_shift_op)  |
                   (op_code_i == bfu_rotate_left_carry_op)  |
                   (op_code_i == bfu_rotate_right_carry_op) |
                   (op_code_i == bfu_arith_right_shift_op)  |
                   (op_code_i == bfu_nibble_swap_op);
  wire is_bld    = (op_code_i == bfu_transfer_flag_to_bit_op);
  wire is_sleep  = (op_code_i == bfu_sleep_op);
  wire is_wdr    = (op_code_i == bfu_watchdog_restart_op);

  // selected-bit mask shared by the read-modify-write paths
  wire [7:0] sel_mask = bfu_bit_mask(op_bit_i);

  // datapath
  // every result is formed each cycle from the offered operands;
  // the strobes further down decide which of them lands anywhere

  // shifter results
  wire [7:0] sh_result;   // shifted or swapped value
  wire       sh_carry;    // carry out
  wire       sh_zero;     // zero result
  wire       sh_neg;      // negative result
  wire       sh_ovf;      // overflow, n xor c

  bfu_shift u_shift (
    .op_i     (op_code_i),
    .data_i   (op_rd_data_i),
    .carry_i  (flags_o[`BFU_FLAG_C]),
    .result_o (sh_result),
    .carry_o  (sh_carry),
    .zero_o   (sh_zero),
    .neg_o    (sh_neg),
    .ovf_o    (sh_ovf)
  );

  // bit load: only the chosen bit takes T, the rest stay
  wire [7:0] bld_result = flags_o[`BFU_FLAG_T] ? (op_rd_data_i | sel_mask)
                                               : (op_rd_data_i & ~sel_mask);

  // write-back value for the working register
  wire [7:0] wb_value = is_bld ? bld_result : sh_result;

  // I/O read-modify-write: only the chosen bit changes
  wire [7:0] io_set_val = op_io_data_i | sel_mask;
  wire [7:0] io_clr_val = op_io_data_i & ~sel_mask;
  wire [7:0] io_value   = is_io_set ? io_set_val : io_clr_val;

  // bit store source bit out of the register operand
  wire store_bit = op_rd_data_i[op_bit_i];

  // flags after the instruction; I/O, swap, bit load, sleep,
  // watchdog and idle all pass the flags through unchanged
  wire [7:0] op_flags;

  bfu_flags u_flags (
    .op_i    (op_code_i),
    .flags_i (flags_o),
    .sel_i   (op_bit_i),
    .tbit_i  (store_bit),
    .arith_i ({sh_ovf, sh_neg, sh_zero, sh_carry}),
    .flags_o (op_flags)
  );

  // register port decode
  // only the low byte of the flags and status words and the low half of the retire word are mapped, the rest reads zero;
  // a write to the status offset has no storage and is dropped

  wire hit_flags  = (reg_addr_i == `BFU_OFF_FLAGS);   // flags register
  wire hit_status = (reg_addr_i == `BFU_OFF_STATUS);  // unit status, read only
  wire hit_retire = (reg_addr_i == `BFU_OFF_RETIRE);  // retire counter

  wire wr_flags  = reg_we_i & hit_flags;   // software flag write
  wire wr_retire = reg_we_i & hit_retire;  // any write clears the counter

  // unit status view: busy bit and the code of the last instruction,
  // placed by the field macros so software and logic share one map
  wire         io_busy = (state == bfu_st_io_write);  // I/O write still pending
  logic [31:0] status_word;                            // assembled status view

  // unused status bits read as zero
  always_comb
  begin
    status_word                                    = 32'h00000000;
    status_word[`BFU_STAT_BUSY]                    = io_busy;
    status_word[`BFU_STAT_OP_MSB:`BFU_STAT_OP_LSB] = last_op;
  end

  // read mux; an unmapped address reads as zero
  wire [31:0] read_mux = hit_flags  ? {24'h000000, flags_o} :
                         hit_status ? status_word :
                         hit_retire ? {16'h0000, retire_cnt} : 32'h00000000;

  // issue sequencer
  // the only behaviour spanning more than one cycle lives here;
  // two states, so an illegal code can only come from a flipped bit

  // I/O ops hold the port for a second cycle to finish the write;
  // everything else completes in the cycle it is taken
  always_comb
  begin
    next_state = state;
    unique case (state)
      bfu_st_idle:
      begin
        // a taken I/O op occupies one more cycle
        if (accept && is_io_op)
        begin
          next_state = bfu_st_io_write;
        end
      end
      bfu_st_io_write:
      begin
        // write strobe rises and the port frees at the next edge
        next_state = bfu_st_idle;
      end
      default:
      begin
        // illegal one-hot code, recover to idle
        next_state = bfu_st_idle;
      end
    endcase
  end

  // sequencer state register
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      state <= bfu_st_idle;
    else
      state <= next_state;
  end

  // ready drops for the second cycle of an I/O op only
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      op_ready_o <= 1'b0;
    else
      op_ready_o <= (next_state == bfu_st_idle);
  end

  // I/O write path
  // the core owns the I/O space; this unit proposes one write and
  // leaves arbitration with other writers to the core

  // address and value are captured when the op is taken, so the core
  // may move on to the next operand while the write is pending
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      io_addr_o <= 6'h00;
      io_data_o <= 8'h00;
    end
    else if (accept && is_io_op)
    begin
      io_addr_o <= op_io_addr_i;
      io_data_o <= io_value;
    end
  end

  // strobe rises in the cycle after the stall, once the port is free again;
  // driving it from state rather than accept means address and
  // data have already settled for a full cycle when it rises
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      io_we_o <= 1'b0;
    else
      io_we_o <= (state == bfu_st_io_write);
  end

  // working register write-back
  // the core merges this write into its register file; nothing
  // here forwards the value to a following instruction

  // shifts, swap and bit load write back one cycle after issue
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      rd_we_o   <= 1'b0;
      rd_addr_o <= 5'h00;
      rd_data_o <= 8'h00;
    end
    else
    begin
      rd_we_o <= accept & (is_shift | is_bld);
      // data and address only move on a write, so they read as stable
      if (accept && (is_shift || is_bld))
      begin
        rd_addr_o <= op_rd_addr_i;
        rd_data_o <= wb_value;
      end
    end
  end

  // sleep and watchdog hand-off
  // neither power saving nor the watchdog count is modelled here;
  // the unit only marks the cycle in which the request was taken

  // single-cycle pulses; the receiving logic owns what follows
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      sleep_req_o   <= 1'b0;
      wdt_restart_o <= 1'b0;
    end
    else
    begin
      sleep_req_o   <= accept & is_sleep;
      wdt_restart_o <= accept & is_wdr;
    end
  end

  // status flags register
  // the single piece of architectural state held by this unit;
  // it also feeds the carry into the rotates and T into bit load

  // a software write overrides an instruction in the same cycle; the
  // core is expected not to race itself, so the simpler priority won
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      flags_o <= `BFU_FLAGS_RST;
    else if (wr_flags)
      flags_o <= reg_wdata_i[7:0];
    else if (accept)
      flags_o <= op_flags;
  end

  // bookkeeping visible to software
  // debug aids only; no instruction reads them back, and
  // a reset clears them together with everything else

  // retire counter wraps silently; a clear beats a count
  // sixteen bits is plenty between two clears in a debug session
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      retire_cnt <= `BFU_RETIRE_RST;
    else if (wr_retire)
      retire_cnt <= `BFU_RETIRE_RST;
    else if (accept)
      retire_cnt <= retire_cnt + 16'h0001;
  end

  // last taken instruction code, for debug reads
  // the illegal code is recorded too, which helps spot a bad fetch
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      last_op <= 4'h0;
    else if (accept)
      last_op <= op_code_i;
  end

  // read data stands only in the cycle after the read strobe
  // returning zero otherwise keeps stale words off the port
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      reg_rdata_o <= 32'h00000000;
    else if (reg_re_i)
      reg_rdata_o <= read_mux;
    else
      reg_rdata_o <= 32'h00000000;
  end

endmodule : bfu_unit

// *** bfu_unit_assertions.sv ***
`timescale 1ns/10ps
// timing and result checks on the issue port of the bit and flag unit
module bfu_unit_checker
  import bfu_pkg::*;
(
  input wire logic       mclk_i,         // core clock
  input wire logic       rst_i,          // synchronous reset
  input wire logic       op_valid_i,     // instruction offered
  input wire bfu_op_t    op_code_i,      // instruction code
  input wire logic [2:0] op_bit_i,       // bit or flag index
  input wire logic [7:0] op_rd_data_i,   // working register operand
  input wire logic [7:0] op_io_data_i,   // current I/O value
  input wire logic       op_ready_o,     // unit can take
  input wire logic       rd_we_o,        // write-back strobe
  input wire logic [7:0] rd_data_o,      // write-back value
  input wire logic       io_we_o,        // I/O write strobe
  input wire logic [7:0] io_data_o,      // I/O write value
  input wire logic       sleep_req_o,    // sleep hand-off
  input wire logic       wdt_restart_o,  // watchdog hand-off
  input wire logic [7:0] flags_o,        // status flags
  input wire logic       reg_we_i        // software write strobe
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  logic       took;     // an instruction was taken at the last edge
  bfu_op_t    p_code;   // its code
  logic [2:0] p_bit;    // its index
  logic [7:0] p_data;   // its register operand
  logic [7:0] p_io;     // its I/O operand
  logic [7:0] p_flags;  // flags before it
  logic       p_we;     // software write beside it replaces the flags, so skip
  wire        ok = took && !p_we;
  wire        shift_op = p_code >= bfu_logic_left_shift_op && p_code <= bfu_arith_right_shift_op;

  // operands of each taken instruction, seen one cycle later
  always_ff @(posedge mclk_i)
  begin
    took    <= !rst_i && op_valid_i && op_ready_o;
    p_code  <= op_code_i;
    p_bit   <= op_bit_i;
    p_data  <= op_rd_data_i;
    p_io    <= op_io_data_i;
    p_flags <= flags_o;
    p_we    <= reg_we_i;
  end

  // second cycle of an I/O op: stalled, then one write strobe
  sequence io_stall_s;
    !op_ready_o && !io_we_o && flags_o == p_flags;
  endsequence
  sequence io_write_s;
    op_ready_o && io_we_o ##1 !io_we_o;
  endsequence

  io_bit_set_a: assert property (ok && p_code == bfu_io_bit_set_op |->
    io_data_o == (p_io | (8'h01 << p_bit)) ##0 io_stall_s ##1 io_write_s)
    else $error("I/O bit set wrong");
  io_bit_clear_a: assert property (ok && p_code == bfu_io_bit_clear_op |->
    io_data_o == (p_io & ~(8'h01 << p_bit)) ##0 io_stall_s ##1 io_write_s)
    else $error("I/O bit clear wrong");
  rotate_left_a: assert property (ok && p_code == bfu_rotate_left_carry_op |->
    rd_we_o && rd_data_o == {p_data[6:0], p_flags[0]} && flags_o[0] == p_data[7])
    else $error("rotate left wrong");
  rotate_right_a: assert property (ok && p_code == bfu_rotate_right_carry_op |->
    rd_we_o && rd_data_o == {p_flags[0], p_data[7:1]} && flags_o[0] == p_data[0])
    else $error("rotate right wrong");
  arith_shift_a: assert property (ok && p_code == bfu_arith_right_shift_op |->
    rd_we_o && rd_data_o == {p_data[7], p_data[7:1]} && flags_o[0] == p_data[0])
    else $error("arithmetic shift wrong");
  shift_flags_a: assert property (ok && shift_op |-> flags_o[7:4] == p_flags[7:4] &&
    flags_o[1] == (rd_data_o == 8'h00) && flags_o[2] == rd_data_o[7] &&
    flags_o[3] == (rd_data_o[7] ^ flags_o[0]))
    else $error("shift flags wrong");
  nibble_swap_a: assert property (ok && p_code == bfu_nibble_swap_op |->
    rd_we_o && rd_data_o == {p_data[3:0], p_data[7:4]} && flags_o == p_flags)
    else $error("nibble swap wrong");
  bit_store_a: assert property (ok && p_code == bfu_bit_to_transfer_flag_op |->
    flags_o == {p_flags[7], p_data[p_bit], p_flags[5:0]})
    else $error("bit store wrong");
  bit_load_a: assert property (ok && p_code == bfu_transfer_flag_to_bit_op |-> rd_we_o &&
    rd_data_o == ((p_data & ~(8'h01 << p_bit)) | ({7'h00, p_flags[6]} << p_bit)) &&
    flags_o == p_flags)
    else $error("bit load wrong");
  flag_set_a: assert property (
    ok && p_code == bfu_generic_flag_set_op |-> flags_o == (p_flags | (8'h01 << p_bit)))
    else $error("flag set wrong");
  flag_clear_a: assert property (
    ok && p_code == bfu_generic_flag_clear_op |-> flags_o == (p_flags & ~(8'h01 << p_bit)))
    else $error("flag clear wrong");
  sleep_pulse_a: assert property (sleep_req_o == (took && p_code == bfu_sleep_op))
    else $error("sleep pulse wrong");
  wdt_pulse_a: assert property (
    wdt_restart_o == (took && p_code == bfu_watchdog_restart_op))
    else $error("watchdog pulse wrong");
endmodule : bfu_unit_checker

bind bfu_unit bfu_unit_checker i_bfu_unit_checker (
  .mclk_i, .rst_i, .op_valid_i, .op_code_i, .op_bit_i, .op_rd_data_i, .op_io_data_i,
  .op_ready_o, .rd_we_o, .rd_data_o, .io_we_o, .io_data_o, .sleep_req_o, .wdt_restart_o,
  .flags_o, .reg_we_i
);

// *** test_bfu_unit.sv ***
`timescale 1ns/10ps
// self-checking bench: random operands through every code, register port
module test_bfu_unit
  import bfu_pkg::*;
;
  logic        mclk_i, rst_i, op_valid_i, reg_we_i, reg_re_i;
  bfu_op_t     op_code_i;
  logic [2:0]  op_bit_i;
  logic [4:0]  op_rd_addr_i;
  logic [7:0]  op_rd_data_i, op_io_data_i, reg_addr_i;
  logic [5:0]  op_io_addr_i;
  logic [31:0] reg_wdata_i;
  wire logic   op_ready_o, rd_we_o, io_we_o, sleep_req_o, wdt_restart_o;
  wire logic [4:0]  rd_addr_o;
  wire logic [5:0]  io_addr_o;
  wire logic [7:0]  rd_data_o, io_data_o, flags_o;
  wire logic [31:0] reg_rdata_o;
  logic [7:0]  mf;                        // model of the flags register
  logic [13:0] io_q[$];                   // expected I/O writes, oldest first
  int          errors, checked, retired;  // counts; retired mirrors the counter

  bfu_unit i_bfu_unit (.mclk_i, .rst_i, .op_valid_i, .op_code_i, .op_bit_i, .op_rd_addr_i,
    .op_rd_data_i, .op_io_addr_i, .op_io_data_i, .op_ready_o, .rd_we_o, .rd_addr_o,
    .rd_data_o, .io_we_o, .io_addr_o, .io_data_o, .sleep_req_o, .wdt_restart_o, .flags_o,
    .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o);

  // 125 MHz core clock
  initial
  begin
    mclk_i = 1'h0;
    forever #4 mclk_i = ~mclk_i;
  end

  // one value compare, an unknown bit matches only an unknown bit
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // issue one instruction with random operands, model it, check the answer
  task automatic issue(input bfu_op_t c);
    logic [7:0] d, io, r, eio;
    logic [2:0] b;
    logic [5:0] ia;
    logic [4:0] ra;
    logic       cy, we;
    d = 8'($urandom);
    io = 8'($urandom);
    b = 3'($urandom);
    ia = 6'($urandom);
    ra = 5'($urandom);
    op_valid_i <= 1'h1;
    op_code_i <= c;
    op_bit_i <= b;
    op_rd_data_i <= d;
    op_io_data_i <= io;
    op_io_addr_i <= ia;
    op_rd_addr_i <= ra;
    r = d;
    cy = mf[0];
    we = 1'h1;
    eio = (c == bfu_io_bit_set_op) ? io | (8'h01 << b) : io & ~(8'h01 << b);
    case (c)
      bfu_logic_left_shift_op:     {cy, r} = {d, 1'h0};
      bfu_logic_right_shift_op:    {r, cy} = {1'h0, d};
      bfu_rotate_left_carry_op:    {cy, r} = {d, mf[0]};
      bfu_rotate_right_carry_op:   {r, cy} = {mf[0], d};
      bfu_arith_right_shift_op:    {r, cy} = {d[7], d};
      bfu_nibble_swap_op:          r = {d[3:0], d[7:4]};
      bfu_transfer_flag_to_bit_op: r[b] = mf[6];
      default:                     we = 1'h0;
    endcase
    // only shifts and rotates touch the arithmetic flags, never S
    if (c >= bfu_logic_left_shift_op && c <= bfu_arith_right_shift_op)
      mf[3:0] = {r[7] ^ cy, r[7], r == 8'h00, cy};
    if (c == bfu_generic_flag_set_op)
      mf[b] = 1'h1;
    if (c == bfu_generic_flag_clear_op)
      mf[b] = 1'h0;
    if (c == bfu_bit_to_transfer_flag_op)
      mf[6] = d[b];
    @(posedge mclk_i);
    #1;
    retired++;
    cmp(flags_o, mf);
    cmp({rd_we_o, we ? rd_data_o : 8'h00}, {we, we ? r : 8'h00});
    cmp(we ? rd_addr_o : 5'h00, we ? ra : 5'h00);
    cmp(sleep_req_o, c == bfu_sleep_op);
    cmp(wdt_restart_o, c == bfu_watchdog_restart_op);
    if (c == bfu_io_bit_set_op || c == bfu_io_bit_clear_op)
    begin
      // valid stays up during the stall: that request must be ignored
      io_q.push_back({ia, eio});
      cmp({op_ready_o, io_we_o, io_addr_o, io_data_o}, {2'h0, ia, eio});
      @(posedge mclk_i);
      #1;
      cmp({op_ready_o, io_we_o, flags_o}, {2'h3, mf});
      cmp({io_addr_o, io_data_o}, io_q.pop_front());
    end
  endtask : issue

  // register write, one strobe cycle
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    reg_we_i <= 1'h1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge mclk_i);
    reg_we_i <= 1'h0;
    #1;
  endtask : reg_wr

  // register read, data in the following cycle
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    reg_re_i <= 1'h1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_re_i <= 1'h0;
    #1;
    cmp(reg_rdata_o, exp);
  endtask : reg_rd

  task automatic complete_run;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  // main sequence
  initial
  begin
    {op_valid_i, op_bit_i, op_rd_addr_i, op_rd_data_i, op_io_addr_i, op_io_data_i} = '0;
    {reg_addr_i, reg_wdata_i, reg_we_i, reg_re_i} = '0;
    op_code_i = bfu_idle_instruction;
    {errors, checked, retired} = '0;
    mf = 8'h00;
    void'($urandom(32'hF7F7));
    rst_i = 1'h1;
    repeat (3) @(posedge mclk_i);
    #1;
    cmp({op_ready_o, flags_o}, 32'h0);
    rst_i <= 1'h0;
    @(posedge mclk_i);
    #1;
    reg_wr(8'h00, 32'hFFFF_FF5A);
    mf = 8'h5A;
    reg_rd(8'h00, 32'h5A);
    reg_wr(8'h0C, 32'hFF);
    reg_wr(8'h04, 32'hFF);
    reg_rd(8'h0C, 32'h0);
    // every code including the illegal one, back to back, three passes
    for (int k = 0; k < 48; k++)
      issue(bfu_op_t'(4'(k)));
    op_valid_i <= 1'h0;
    reg_rd(8'h08, 32'(retired));
    reg_rd(8'h04, 32'hF0);
    reg_wr(8'h08, 32'h1);
    reg_rd(8'h08, 32'h0);
    reg_rd(8'h00, 32'(mf));
    // reset in mid-run clears the flags again
    rst_i <= 1'h1;
    @(posedge mclk_i);
    #1;
    cmp({op_ready_o, flags_o}, 32'h0);
    rst_i <= 1'h0;
    // ready returns one edge after release, then an op is taken again
    @(posedge mclk_i);
    #1;
    cmp(op_ready_o, 32'h1);
    mf = 8'h00;
    issue(bfu_rotate_left_carry_op);
    complete_run();
  end

  // hang guard, far beyond the 71 cycles needed
  initial
  begin
    #100000;
    errors++;
    complete_run();
  end
endmodule : test_bfu_unit
